// ===== verilog/bce_engine.sv
// bce_engine: block cipher engine behind a byte-wide memory-style window
// assumes: one byte access per clock cycle with i_acc_en high, bursts step the address by one
//
// How it works
// - all control, key and data live only in window 0x82 to 0x94
// - 128-bit key and block cipher in hardware, both directions
// - codebook mode both ways, chained mode for encryption only
// - engine runs with no dependence on the radio blocks
// - separate initial key store, never changed by a run
// - key and data share 0x84..0x93; mode field picks the page
// - mode 0 is codebook; direction bit picks encrypt or decrypt
// - request bit written as 1 at 0x83 or 0x94 starts a run in mode 0, or in mode 2 when encrypting
// - 0x94 mirrors the control byte at 0x83
// - setup, data and start fit in one incrementing write burst
// - no register outside the window is needed
// - accesses are refused during sleep or reset
// - reset clears configuration, data page and all keys
// - any access to 0x83 during a run aborts it
// - key page reads return the last round key
// - each run starts from the stored initial key
// - a write returns the old byte at that address at once
// - mode 2 chains: previous result XORed into new input
// - direction 0 means encryption
// - one run lasts 23.4 us
// - old result byte returned at the same clock edge that takes its new input byte
`timescale 1ns/100ps
`default_nettype none

module bce_engine #(
  parameter int unsigned RUN_CYC = bce_pkg::AES_RUN_CYC
) (
  // clock and reset
  input  wire logic       i_ref_clk,
  input  wire logic       i_resetn,
  // transceiver state
  input  wire logic       i_trx_sleep,
  // window access
  input  wire logic       i_acc_en,
  input  wire logic       i_acc_we,
  input  wire logic [7:0] i_acc_addr,
  input  wire logic [7:0] i_acc_wdata,
  // answers
  output logic      [7:0] o_acc_rdata,
  output logic            o_busy
);
  import bce_pkg::*;

  typedef struct packed {
    bce_state_t       st;
    logic             busy;
    logic [2:0]       mode;
    logic             dir;
    logic             run_dec;
    logic [0:15][7:0] init_key;
    logic [0:15][7:0] rkey;
    logic [0:15][7:0] data;
    logic [127:0]     chain;
    logic [127:0]     state;
    logic [3:0]       rnd;
    logic [9:0]       cyc;
    logic [7:0]       rdata;
  } bce_regs_t;

  bce_regs_t   r_reg;
  bce_regs_t   r_next;
  bce_round_if rif ();

  bce_round u_round (
    .rif (rif.rnd)
  );

  // ----------------------------------------------------------------
  // window decode
  // ----------------------------------------------------------------
  logic       acc;
  logic       on_ctrl;
  logic       on_copy;
  logic       on_page;
  logic [7:0] off;
  logic [3:0] idx;
  logic       key_pg;
  logic [7:0] ctrl_byte;
  logic [7:0] rd;
  logic [2:0] wmode;
  logic       start;
  logic [127:0] blk_in;

  always_comb begin
    acc     = i_acc_en && !i_trx_sleep;
    off     = i_acc_addr - ADDR_PAGE_LO;
    idx     = off[3:0];
    on_ctrl = 1'b0;
    on_copy = 1'b0;
    on_page = 1'b0;
    if (i_acc_addr == ADDR_CTRL) begin
      on_ctrl = 1'b1;
    end else if (i_acc_addr == ADDR_COPY) begin
      on_copy = 1'b1;
    end else if (i_acc_addr >= ADDR_PAGE_LO && i_acc_addr <= ADDR_PAGE_HI) begin
      on_page = 1'b1;
    end
    key_pg    = r_reg.mode == MODE_KEY;
    ctrl_byte = {r_reg.busy, r_reg.mode, r_reg.dir, 3'h0};
    rd        = 8'h00;
    if (on_ctrl || on_copy) begin
      rd = ctrl_byte;
    end else if (on_page) begin
      rd = key_pg ? r_reg.rkey[idx] : r_reg.data[idx];
    end
    wmode  = i_acc_wdata[CTRL_MODE_HI:CTRL_MODE_LO];
    // key mode loads keys only; decryption is offered in codebook mode only
    start  = acc && i_acc_we && (on_ctrl || on_copy) && i_acc_wdata[CTRL_REQ_BIT]
             && (wmode == MODE_ECB
                 || (wmode == MODE_CBC && i_acc_wdata[CTRL_DIR_BIT] == DIR_ENC));
    blk_in = r_reg.data;
    if (wmode == MODE_CBC) blk_in = r_reg.data ^ r_reg.chain;
  end

  // ----------------------------------------------------------------
  // round feed
  // ----------------------------------------------------------------
  always_comb begin
    rif.state   = r_reg.state;
    rif.key     = r_reg.rkey;
    rif.decrypt = r_reg.run_dec;
    rif.last    = r_reg.rnd == AES_ROUNDS;
    rif.rcon    = bce_rcon(r_reg.run_dec ? RCON_DEC_TOP - r_reg.rnd : r_reg.rnd);
  end

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  always_comb begin
    r_next = r_reg;
    // the engine sees no radio state beyond sleep
    if (r_reg.busy) r_next.cyc = r_reg.cyc + 10'h001;
    case (r_reg.st)
      BCE_ROUND: begin
        r_next.state = rif.nstate;
        r_next.rkey  = rif.nkey;
        if (rif.last) begin
          r_next.st = BCE_HOLD;
        end else begin
          r_next.rnd = r_reg.rnd + 4'h1;
        end
      end
      BCE_HOLD: begin
        // result held back until the documented run time elapses
        if (r_reg.cyc >= RUN_CYC[9:0]) begin
          r_next.data  = r_reg.state;
          r_next.chain = r_reg.state;
          r_next.busy  = 1'b0;
          r_next.st    = BCE_IDLE;
        end
      end
      default: begin
        r_next.st = BCE_IDLE;
      end
    endcase

    r_next.rdata = 8'h00;
    if (acc) begin
      // old content leaves on the same edge as the new byte lands
      r_next.rdata = rd;
      if (on_ctrl && r_reg.busy) begin
        r_next.st   = BCE_IDLE;
        r_next.busy = 1'b0;
      end
      if (i_acc_we) begin
        // each byte decodes on its own, so one burst does it all
        if (on_ctrl || on_copy) begin
          r_next.mode = wmode;
          r_next.dir  = i_acc_wdata[CTRL_DIR_BIT];
        end
        if (on_page && key_pg) begin
          r_next.init_key[idx] = i_acc_wdata;
          r_next.rkey[idx]     = i_acc_wdata;
        end else if (on_page) begin
          r_next.data[idx] = i_acc_wdata;
        end
      end
    end
    if (start) begin
      r_next.run_dec = i_acc_wdata[CTRL_DIR_BIT] != DIR_ENC;
      r_next.state   = blk_in ^ r_reg.init_key;
      r_next.rkey    = r_reg.init_key;
      r_next.rnd     = 4'h1;
      r_next.cyc     = 10'h001;
      r_next.busy    = 1'b1;
      r_next.st      = BCE_ROUND;
    end
  end

  always_ff @(posedge i_ref_clk) begin
    if (!i_resetn) begin
      r_reg <= '0;
    end else begin
      r_reg <= r_next;
    end
  end

  assign o_acc_rdata = r_reg.rdata;
  assign o_busy      = r_reg.busy;

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  run_start_a: assert property (
    @(posedge i_ref_clk) disable iff (!i_resetn)
    start |=> o_busy && r_reg.st == BCE_ROUND && r_reg.rnd == 4'h1)
    else $error("request did not start a run");

  run_abort_a: assert property (
    @(posedge i_ref_clk) disable iff (!i_resetn)
    acc && on_ctrl && o_busy && !start |=> !o_busy ##1 !o_busy)
    else $error("control access did not abort the run");

  copy_read_a: assert property (
    @(posedge i_ref_clk) disable iff (!i_resetn)
    acc && on_copy && !i_acc_we |=> o_acc_rdata[CTRL_REQ_BIT] == $past(o_busy)
      && o_acc_rdata[CTRL_MODE_HI:CTRL_MODE_LO] == $past(r_reg.mode))
    else $error("mirror byte differs from control byte");

  sleep_refuse_a: assert property (
    @(posedge i_ref_clk) disable iff (!i_resetn)
    i_acc_en && i_trx_sleep && !o_busy |=> o_acc_rdata == 8'h00
      && $stable(r_reg.init_key) && $stable(r_reg.data) && $stable(r_reg.mode))
    else $error("access accepted while asleep");

  key_hold_a: assert property (
    @(posedge i_ref_clk) disable iff (!i_resetn)
    o_busy && !(acc && i_acc_we && on_page && key_pg) |=> $stable(r_reg.init_key))
    else $error("initial key altered by a run");

  run_len_a: assert property (
    @(posedge i_ref_clk) disable iff (!i_resetn)
    $fell(o_busy) && $past(r_reg.st) == BCE_HOLD |-> $past(r_reg.cyc) == RUN_CYC[9:0]
      && r_reg.data == $past(r_reg.state))
    else $error("run length or result wrong");

  key_read_a: assert property (
    @(posedge i_ref_clk) disable iff (!i_resetn)
    acc && on_page && key_pg && !i_acc_we && !o_busy
      |=> o_acc_rdata == $past(r_reg.rkey[idx]))
    else $error("key page read is not the round key");

  fast_read_a: assert property (
    @(posedge i_ref_clk) disable iff (!i_resetn)
    acc && i_acc_we && on_page && !key_pg && !o_busy
      |=> o_acc_rdata == $past(r_reg.data[idx]) && r_reg.data[$past(idx)] == $past(i_acc_wdata))
    else $error("write did not return the previous byte");

  page_split_a: assert property (
    @(posedge i_ref_clk) disable iff (!i_resetn)
    acc && i_acc_we && on_page && !key_pg |=> $stable(r_reg.init_key))
    else $error("data write reached the key page");

  rdata_idle_a: assert property (
    @(posedge i_ref_clk) disable iff (!i_resetn)
    !acc |=> o_acc_rdata == 8'h00)
    else $error("read byte shown without an access");

  reset_clear_a: assert property (
    @(posedge i_ref_clk)
    !i_resetn |=> !o_busy && o_acc_rdata == 8'h00 && r_reg.mode == MODE_ECB
      && r_reg.init_key == '0 && r_reg.rkey == '0 && r_reg.data == '0 && r_reg.chain == '0)
    else $error("reset left engine state behind");

  seed_key_a: assert property (
    @(posedge i_ref_clk) disable iff (!i_resetn)
    start |=> r_reg.rkey == $past(r_reg.init_key))
    else $error("run did not start from the initial key");

  chain_input_a: assert property (
    @(posedge i_ref_clk) disable iff (!i_resetn)
    start && wmode == MODE_CBC
      |=> r_reg.state == ($past(r_reg.data) ^ $past(r_reg.chain) ^ $past(r_reg.init_key)))
    else $error("chained input not combined with previous result");

  start_refuse_a: assert property (
    @(posedge i_ref_clk) disable iff (!i_resetn)
    acc && i_acc_we && (on_ctrl || on_copy) && i_acc_wdata[CTRL_REQ_BIT] && !o_busy
      && (wmode == MODE_KEY || wmode > MODE_CBC
          || (wmode == MODE_CBC && i_acc_wdata[CTRL_DIR_BIT] != DIR_ENC))
      |=> !o_busy)
    else $error("refused request started a run");

  copy_keep_a: assert property (
    @(posedge i_ref_clk) disable iff (!i_resetn)
    acc && on_copy && o_busy && r_reg.st == BCE_ROUND |=> o_busy)
    else $error("mirror access aborted the run");

  ctrl_read_a: assert property (
    @(posedge i_ref_clk) disable iff (!i_resetn)
    acc && on_ctrl && !i_acc_we |=> o_acc_rdata[CTRL_REQ_BIT] == $past(o_busy)
      && o_acc_rdata[CTRL_DIR_BIT] == $past(r_reg.dir))
    else $error("control byte read lost the request bit");

endmodule

`default_nettype wire

// ===== verilog/bce_pkg.sv
// bce_pkg: address map, control fields, modes, timing and cipher constants
// assumes: one 40 MHz reference clock, byte-wide window accesses
`default_nettype none

package bce_pkg;

  // ----------------------------------------------------------------
  // window addresses
  // ----------------------------------------------------------------
  localparam logic [7:0] ADDR_LO      = 8'h82;
  localparam logic [7:0] ADDR_CTRL    = 8'h83;
  localparam logic [7:0] ADDR_PAGE_LO = 8'h84;
  localparam logic [7:0] ADDR_PAGE_HI = 8'h93;
  localparam logic [7:0] ADDR_COPY    = 8'h94;

  // ----------------------------------------------------------------
  // control byte layout and values
  // ----------------------------------------------------------------
  localparam int         CTRL_REQ_BIT = 7;
  localparam int         CTRL_MODE_HI = 6;
  localparam int         CTRL_MODE_LO = 4;
  localparam int         CTRL_DIR_BIT = 3;
  localparam logic [2:0] MODE_ECB     = 3'h0;
  localparam logic [2:0] MODE_KEY     = 3'h1;
  localparam logic [2:0] MODE_CBC     = 3'h2;
  localparam logic       DIR_ENC      = 1'b0;
  localparam logic [7:0] CTRL_RESET   = 8'h00;

  // ----------------------------------------------------------------
  // timing
  // ----------------------------------------------------------------
  localparam int unsigned AES_T_NS    = 23400;
  localparam int unsigned CLK_MHZ     = 40;
  localparam int unsigned AES_RUN_CYC = (AES_T_NS * CLK_MHZ + 999) / 1000;

  // ----------------------------------------------------------------
  // cipher constants
  // ----------------------------------------------------------------
  localparam logic [3:0]  AES_ROUNDS   = 4'ha;
  localparam logic [3:0]  RCON_DEC_TOP = 4'hb;
  localparam logic [7:0]  GF_POLY      = 8'h1b;
  localparam logic [7:0]  SBOX_C       = 8'h63;
  localparam logic [7:0]  ISBOX_C      = 8'h05;
  localparam logic [31:0] MIX_FWD      = 32'h02030101;
  localparam logic [31:0] MIX_INV      = 32'h0e0b0d09;

  typedef enum logic [1:0] {
    BCE_IDLE  = 2'h0,
    BCE_ROUND = 2'h1,
    BCE_HOLD  = 2'h3
  } bce_state_t;

  function automatic logic [7:0] bce_rcon(input logic [3:0] r);
    case (r)
      4'h1:    return 8'h01;
      4'h2:    return 8'h02;
      4'h3:    return 8'h04;
      4'h4:    return 8'h08;
      4'h5:    return 8'h10;
      4'h6:    return 8'h20;
      4'h7:    return 8'h40;
      4'h8:    return 8'h80;
      4'h9:    return 8'h1b;
      4'ha:    return 8'h36;
      default: return 8'h00;
    endcase
  endfunction

endpackage

`default_nettype wire

// ===== verilog/bce_round_if.sv
// bce_round_if: carries one cipher round between engine and round logic
// assumes: round logic is purely combinational
`timescale 1ns/100ps
`default_nettype none

interface bce_round_if;
  logic [127:0] state;
  logic [127:0] key;
  logic         decrypt;
  logic         last;
  logic [7:0]   rcon;
  logic [127:0] nstate;
  logic [127:0] nkey;

  modport eng (output state, key, decrypt, last, rcon, input nstate, nkey);
  modport rnd (input state, key, decrypt, last, rcon, output nstate, nkey);
endinterface

`default_nettype wire

// ===== verilog/bce_round.sv
// bce_round: one forward or inverse cipher round plus its key step
// assumes: engine registers the results each cycle
`timescale 1ns/100ps
`default_nettype none

module bce_round (
  bce_round_if.rnd rif
);
  import bce_pkg::*;

  // ----------------------------------------------------------------
  // field arithmetic
  // ----------------------------------------------------------------
  function automatic logic [7:0] gmul(input logic [7:0] a, input logic [7:0] b);
    logic [7:0] p;
    logic [7:0] x;
    p = 8'h00;
    x = a;
    for (int i = 0; i < 8; i++) begin
      if (b[i]) p = p ^ x;
      x = {x[6:0], 1'b0} ^ (x[7] ? GF_POLY : 8'h00);
    end
    return p;
  endfunction

  // inverse as x^254
  function automatic logic [7:0] ginv(input logic [7:0] a);
    logic [7:0] p;
    logic [7:0] r;
    p = a;
    r = 8'h01;
    for (int i = 1; i < 8; i++) begin
      p = gmul(p, p);
      r = gmul(r, p);
    end
    return r;
  endfunction

  function automatic logic [7:0] sbox(input logic [7:0] a);
    logic [7:0] i;
    i = ginv(a);
    return i ^ {i[6:0], i[7]} ^ {i[5:0], i[7:6]} ^ {i[4:0], i[7:5]}
             ^ {i[3:0], i[7:4]} ^ SBOX_C;
  endfunction

  function automatic logic [7:0] isbox(input logic [7:0] a);
    return ginv({a[6:0], a[7]} ^ {a[4:0], a[7:5]} ^ {a[1:0], a[7:2]} ^ ISBOX_C);
  endfunction

  function automatic logic [31:0] kword(input logic [31:0] w, input logic [7:0] rc);
    return {sbox(w[23:16]) ^ rc, sbox(w[15:8]), sbox(w[7:0]), sbox(w[31:24])};
  endfunction

  function automatic logic [0:3][7:0] mixcol(input logic [0:3][7:0] a,
                                             input logic [0:3][7:0] m);
    logic [0:3][7:0] o;
    o = '0;
    for (int r = 0; r < 4; r++) begin
      o[r] = gmul(a[r], m[0]) ^ gmul(a[(r + 1) % 4], m[1])
           ^ gmul(a[(r + 2) % 4], m[2]) ^ gmul(a[(r + 3) % 4], m[3]);
    end
    return o;
  endfunction

  // ----------------------------------------------------------------
  // round datapath
  // ----------------------------------------------------------------
  logic [0:15][7:0] s;
  logic [0:15][7:0] t;
  logic [0:15][7:0] u;
  logic [0:3][31:0] k;
  logic [0:3][31:0] n;

  always_comb begin
    s = rif.state;
    k = rif.key;
    t = '0;
    n = '0;
    if (!rif.decrypt) begin
      n[0] = k[0] ^ kword(k[3], rif.rcon);
      n[1] = k[1] ^ n[0];
      n[2] = k[2] ^ n[1];
      n[3] = k[3] ^ n[2];
      for (int i = 0; i < 16; i++) t[i] = sbox(s[(i + 4 * (i % 4)) % 16]);
      u = t;
      if (!rif.last) begin
        for (int c = 0; c < 4; c++) u[4 * c +: 4] = mixcol(t[4 * c +: 4], MIX_FWD);
      end
      u = u ^ n;
    end else begin
      // walk the key schedule backward from the final round key
      n[3] = k[3] ^ k[2];
      n[2] = k[2] ^ k[1];
      n[1] = k[1] ^ k[0];
      n[0] = k[0] ^ kword(n[3], rif.rcon);
      for (int i = 0; i < 16; i++) t[i] = isbox(s[(i + 16 - 4 * (i % 4)) % 16]);
      t = t ^ n;
      u = t;
      if (!rif.last) begin
        for (int c = 0; c < 4; c++) u[4 * c +: 4] = mixcol(t[4 * c +: 4], MIX_INV);
      end
    end
    rif.nstate = u;
    rif.nkey   = n;
  end

endmodule

`default_nettype wire

// ===== test/bce_host.sv
// bce_host: host model issuing byte accesses to the cipher window
// assumes: tasks are entered just after a clock edge
`timescale 1ns/100ps
`default_nettype none

module bce_host (
  // clock
  input  wire logic       i_ref_clk,
  // answer from engine
  input  wire logic [7:0] i_acc_rdata,
  // window access
  output logic            o_acc_en,
  output logic            o_acc_we,
  output logic      [7:0] o_acc_addr,
  output logic      [7:0] o_acc_wdata
);
  initial begin
    o_acc_en    = 1'b0;
    o_acc_we    = 1'b0;
    o_acc_addr  = 8'h00;
    o_acc_wdata = 8'h00;
  end

  // request held up to its taken edge, answer read just after it
  task automatic acc(input logic we, input logic [7:0] addr, input logic [7:0] wdata,
                     output logic [7:0] rdata);
    o_acc_en    <= 1'b1;
    o_acc_we    <= we;
    o_acc_addr  <= addr;
    o_acc_wdata <= we ? wdata : ~o_acc_wdata;
    @(posedge i_ref_clk);
    #1;
    rdata = i_acc_rdata;
  endtask

  // release the window; larger n makes a slow host
  task automatic idle(input int n);
    o_acc_en    <= 1'b0;
    o_acc_wdata <= ~o_acc_wdata;
    repeat (n) begin
      @(posedge i_ref_clk);
      #1;
    end
  endtask
endmodule

`default_nettype wire

// ===== test/test_bce_engine.sv
// test_bce_engine: self-checking bench for the cipher engine window
// assumes: bce_pkg compiled first, host model in bce_host
`timescale 1ns/100ps
`default_nettype none
`define CHK(got, exp, msg) \
  begin \
    tests_run++; \
    if ((got) !== (exp)) begin \
      num_errors++; \
      $display("unexpected at %0t: %s got %h exp %h", $time, msg, got, exp); \
    end \
  end

module test_bce_engine;
  import bce_pkg::*;
  localparam int unsigned  RUN = 16;
  localparam logic [127:0] KEY = 128'h000102030405060708090a0b0c0d0e0f;
  localparam logic [127:0] PT  = 128'h00112233445566778899aabbccddeeff;
  localparam logic [127:0] CT  = 128'h69c4e0d86a7b0430d8cdb78070b4c55a;
  localparam logic [127:0] RK  = 128'h13111d7fe3944a17f307a78b4d2b30c5;

  logic         i_ref_clk;
  logic         i_resetn;
  logic         i_trx_sleep;
  logic         acc_en;
  logic         acc_we;
  logic [7:0]   acc_addr;
  logic [7:0]   acc_wdata;
  logic [7:0]   acc_rdata;
  logic         busy;
  logic [7:0]   rb;
  logic [127:0] pg;
  logic [7:0]   bad [3] = '{8'h90, 8'ha8, 8'hb0};
  int           n;
  int           gap = 1;
  int           num_errors = 0;
  int           tests_run = 0;

  bce_engine #(.RUN_CYC(RUN)) i_dut (
    .i_ref_clk   (i_ref_clk),
    .i_resetn    (i_resetn),
    .i_trx_sleep (i_trx_sleep),
    .i_acc_en    (acc_en),
    .i_acc_we    (acc_we),
    .i_acc_addr  (acc_addr),
    .i_acc_wdata (acc_wdata),
    .o_acc_rdata (acc_rdata),
    .o_busy      (busy)
  );

  bce_host i_host (
    .i_ref_clk   (i_ref_clk),
    .i_acc_rdata (acc_rdata),
    .o_acc_en    (acc_en),
    .o_acc_we    (acc_we),
    .o_acc_addr  (acc_addr),
    .o_acc_wdata (acc_wdata)
  );

  // ------------------------------------------------------------
  // access tasks
  // ------------------------------------------------------------
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    logic [7:0] r;
    i_host.acc(1'b1, a, d, r);
    i_host.idle(gap);
  endtask

  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    i_host.acc(1'b0, a, 8'h00, d);
    i_host.idle(gap);
  endtask

  // control, 16 page bytes, optional start, one burst; leaves window held
  task automatic burst(input logic [7:0] ctrl, input logic [127:0] blk,
                       input logic [7:0] go, output logic [127:0] old);
    logic [7:0] r;
    i_host.acc(1'b1, ADDR_CTRL, ctrl, r);
    for (int i = 0; i < 16; i++) begin
      i_host.acc(1'b1, ADDR_PAGE_LO + 8'(i), blk[127-8*i -: 8], r);
      old[127-8*i -: 8] = r;
    end
    if (go !== 8'h00) begin
      i_host.acc(1'b1, ADDR_COPY, go, r);
    end
  endtask

  // set control byte, then read the selected page in one burst
  task automatic rpage(input logic [7:0] ctrl, output logic [127:0] p);
    logic [7:0] r;
    i_host.acc(1'b1, ADDR_CTRL, ctrl, r);
    for (int i = 0; i < 16; i++) begin
      i_host.acc(1'b0, ADDR_PAGE_LO + 8'(i), 8'h00, r);
      p[127-8*i -: 8] = r;
    end
    i_host.idle(gap);
  endtask

  task automatic run_wait(output int c);
    c = 0;
    i_host.idle(0);
    while (busy === 1'b1 && c < 1000) begin
      c++;
      @(posedge i_ref_clk);
      #1;
    end
  endtask

  task automatic end_sim();
    $display("comparisons %0d mismatches %0d", tests_run, num_errors);
    if (num_errors == 0 && tests_run > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  // ------------------------------------------------------------
  // clock, watchdog
  // ------------------------------------------------------------
  initial begin
    i_ref_clk = 1'b0;
    forever #12.5 i_ref_clk = ~i_ref_clk;
  end

  initial begin
    #(25 * 5000);
    num_errors++;
    end_sim();
  end

  // ------------------------------------------------------------
  // tests
  // ------------------------------------------------------------
  initial begin
    i_resetn    = 1'b0;
    i_trx_sleep = 1'b0;
    repeat (3) @(posedge i_ref_clk);
    i_resetn <= 1'b1;
    @(posedge i_ref_clk);
    #1;
    rd(ADDR_CTRL, rb);
    `CHK(rb, CTRL_RESET, "ctrl reset")
    wr(ADDR_LO, 8'hff);
    rd(ADDR_LO, rb);
    `CHK(rb, 8'h00, "low byte")
    i_trx_sleep <= 1'b1;
    wr(ADDR_CTRL, 8'h2f);
    i_trx_sleep <= 1'b0;
    rd(ADDR_CTRL, rb);
    `CHK(rb, CTRL_RESET, "sleep write")
    wr(ADDR_CTRL, 8'h2f);
    rd(ADDR_COPY, rb);
    `CHK(rb, 8'h28, "copy byte")
    $display("test registers done");
    gap = 3;
    burst(8'h10, KEY, 8'h00, pg);
    i_host.idle(gap);
    `CHK(pg, 128'h0, "old key")
    rpage(8'h10, pg);
    `CHK(pg, KEY, "key page")
    rpage(8'h00, pg);
    `CHK(pg, 128'h0, "data page")
    $display("test key done");
    burst(8'h00, PT, 8'h80, pg);
    run_wait(n);
    `CHK(n, RUN, "run length")
    rpage(8'h00, pg);
    `CHK(pg, CT, "encrypt")
    rpage(8'h10, pg);
    `CHK(pg, RK, "round key")
    $display("test encrypt done");
    burst(8'h00, PT, 8'h80, pg);
    `CHK(pg, CT, "fast access")
    run_wait(n);
    rpage(8'h00, pg);
    `CHK(pg, CT, "second run")
    $display("test fast done");
    burst(8'h20, CT ^ PT, 8'ha0, pg);
    run_wait(n);
    `CHK(n, RUN, "chain run")
    rpage(8'h20, pg);
    `CHK(pg, CT, "chain")
    $display("test chain done");
    burst(8'h10, RK, 8'h00, pg);
    i_host.idle(gap);
    burst(8'h08, CT, 8'h88, pg);
    run_wait(n);
    rpage(8'h08, pg);
    `CHK(pg, PT, "decrypt")
    $display("test decrypt done");
    gap = 1;
    burst(8'h00, PT, 8'h80, pg);
    i_host.idle(gap);
    rd(ADDR_COPY, rb);
    `CHK(rb[7], 1'b1, "request bit")
    `CHK(busy, 1'b1, "copy read")
    rd(ADDR_CTRL, rb);
    `CHK(busy, 1'b0, "abort")
    wr(ADDR_CTRL, 8'h80);
    `CHK(busy, 1'b1, "ctrl start")
    run_wait(n);
    rd(ADDR_CTRL, rb);
    `CHK(rb[7], 1'b0, "request clear")
    $display("test abort done");
    for (int i = 0; i < 3; i++) begin
      wr(ADDR_CTRL, bad[i]);
      `CHK(busy, 1'b0, "refused start")
    end
    $display("test refuse done");
    burst(8'h00, PT, 8'h80, pg);
    i_host.idle(2);
    i_resetn <= 1'b0;
    i_host.idle(3);
    `CHK(busy, 1'b0, "reset busy")
    i_resetn <= 1'b1;
    i_host.idle(1);
    rd(ADDR_CTRL, rb);
    `CHK(rb, CTRL_RESET, "reset ctrl")
    rpage(8'h10, pg);
    `CHK(pg, 128'h0, "reset key")
    rpage(8'h00, pg);
    `CHK(pg, 128'h0, "reset data")
    $display("test reset done");
    end_sim();
  end
endmodule

`default_nettype wire
